//--- design/debug_cmd_map.svh
// Purpose: constants of the debug command decoder
// Assumes: included by the break timer and by the command decoder
// Notes:   definitions only
`ifndef DEBUG_CMD_MAP_SVH
`define DEBUG_CMD_MAP_SVH

// ----------------------------------------------------------------
// command bytes
// ----------------------------------------------------------------
`define CMD_RD_REV     8'h00
`define CMD_WR_CNT     8'h01
`define CMD_RD_STAT    8'h02
`define CMD_RD_CNT     8'h03
`define CMD_WR_CTL     8'h04
`define CMD_RD_CTL     8'h05
`define CMD_WR_PC      8'h06
`define CMD_RD_PC      8'h07
`define CMD_WR_REG     8'h08
`define CMD_RD_REG     8'h09
`define CMD_WR_PMEM    8'h0A
`define CMD_RD_PMEM    8'h0B
`define CMD_WR_DMEM    8'h0C
`define CMD_RD_DMEM    8'h0D
`define CMD_RD_CRC     8'h0E
`define CMD_STEP       8'h10
`define CMD_STUFF      8'h11
`define CMD_EXEC       8'h12
`define CMD_RD_BAUD    8'h1B

// ----------------------------------------------------------------
// fields, fills, reset values, timing
// ----------------------------------------------------------------
`define CTL_DBGMODE_BIT 7
`define CTL_RESET       8'h00
`define REV_ID_DEFAULT  16'h0100
`define PERIPH_BASE     12'hF00
`define FILL_BYTE       8'hFF
`define FILL_WORD       16'hFFFF
`define SIZE_ZERO_LEN   9'h100
`define BREAK_CLOCKS    4096

`endif

//--- design/debug_cmd_pkg.sv
// Purpose: types shared by the debug command decoder
// Assumes: debug_cmd_map.svh holds the numbers
// Notes:   types only
package debug_cmd_pkg;

   typedef enum logic [2:0] {
      S_CMD, S_OPND, S_RESP, S_WDATA, S_RREQ, S_RDATA, S_BREAK
   } dcd_state_e;

   typedef struct packed {
      dcd_state_e  st;
      logic [7:0]  cmd;
      logic [1:0]  opn;
      logic [23:0] opbuf;
      logic [11:0] addr;
      logic [8:0]  left;
      logic [15:0] rsp;
      logic [1:0]  rsp_n;
      logic        rd_more;
      logic        rd_ok;
      logic [7:0]  ctl;
      logic        cnt_load;
      logic [15:0] cnt_data;
      logic        pc_load;
      logic [15:0] pc_data;
      logic        rf_wr;
      logic        rf_rd;
      logic [11:0] rf_addr;
      logic [7:0]  rf_wdata;
      logic        ext_valid;
      logic        ext_allowed;
      logic [7:0]  ext_code;
      logic        brk_start;
   } dcd_s;

endpackage : debug_cmd_pkg

//--- design/byte_buffer.sv
// Purpose: small ring buffer with valid/ready on both sides
// Assumes: one clock, flush clears all entries
// Notes:   read data come from the storage registers
`timescale 1ns/100ps
module byte_buffer #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 2
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             resetn,
   input  wire logic             flush,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wp;
      logic [AW-1:0]               rp;
      logic [AW:0]                 cnt;
   } buf_s;

   buf_s r_r;
   buf_s r_nxt;
   logic push;
   logic pop;

   function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
      bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction : bump

   assign in_ready  = (r_r.cnt != (AW+1)'(DEPTH));
   assign out_valid = (r_r.cnt != '0);
   assign out_data  = r_r.mem[r_r.rp];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_comb begin
      r_nxt = r_r;
      if (push) begin
         r_nxt.mem[r_r.wp] = in_data;
         r_nxt.wp          = bump(r_r.wp);
      end
      if (pop) begin
         r_nxt.rp = bump(r_r.rp);
      end
      r_nxt.cnt = r_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
      if (flush) begin
         r_nxt.wp  = '0;
         r_nxt.rp  = '0;
         r_nxt.cnt = '0;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         r_r <= '0;
      end else begin
         r_r <= r_nxt;
      end
   end
endmodule : byte_buffer

//--- design/break_timer.sv
// Purpose: holds the link low for a fixed number of clocks
// Assumes: start is a one-cycle pulse; a new start restarts it
// Notes:   busy is the output enable of the open-drain pin
`timescale 1ns/100ps
`include "debug_cmd_map.svh"
module break_timer #(
   parameter int CYCLES = `BREAK_CLOCKS
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic resetn,
   // control
   input  wire logic start,
   output logic      busy
);
   localparam int CW = $clog2(CYCLES + 1);

   typedef struct packed {
      logic          busy;
      logic [CW-1:0] cnt;
   } brk_s;

   brk_s r_r;
   brk_s r_nxt;

   assign busy = r_r.busy;

   always_comb begin
      r_nxt = r_r;
      if (start) begin
         r_nxt.busy = 1'b1;
         r_nxt.cnt  = CW'(CYCLES - 1);
      end else if (r_r.busy) begin
         if (r_r.cnt == '0) begin
            r_nxt.busy = 1'b0;
         end else begin
            r_nxt.cnt = r_r.cnt - 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         r_r <= '0;
      end else begin
         r_r <= r_nxt;
      end
   end

   // low drive stays on for at least 8 clocks once it starts
   brk_len_a: assert property (@(posedge clk) disable iff (!resetn)
      $rose(r_r.busy) |-> r_r.busy [*8])
      else $error("break drive ended early");
endmodule : break_timer

//--- design/debug_command_decoder.sv
// Purpose: command decoder of the debug controller
// Assumes: serial character layer delivers bytes on this clock
// Notes:   responses pass a two-entry buffer toward the link
//
// Notes on behaviour
// - outside debug mode only revision, status, control commands act fully
// - in debug mode all commands run when read protect is clear
// - read protect disables pc, memory, step, stuff, execute commands
// - 0Fh and undefined command bytes are reserved and ignored
// - 00h returns revision major byte then minor byte
// - 01h takes two bytes high first, loads counter only in debug mode
// - 02h returns the status register byte
// - 03h returns inverted counter, high byte first
// - 03h outside debug mode returns FFFFh
// - 04h takes one byte and writes the control register in any mode
// - 05h returns the control register byte
// - 06h takes two bytes, loads pc only in debug without protect
// - 07h returns pc high first, else FFFFh when gated
// - 08h frames address high, address low, size, data; size 0 is 256
// - 08h outside debug mode accepts all bytes but writes nothing
// - with read protect only peripheral register writes happen
// - 09h uses same framing and returns size bytes, 0 meaning 256
// - gated register reads return FFh for every byte
// - after the read operands the data bytes go back to the host
// - link error aborts the command and drives a 4096 clock break
`timescale 1ns/100ps
`include "debug_cmd_map.svh"
module debug_command_decoder
   import debug_cmd_pkg::*;
#(
   parameter logic [15:0] REV_ID     = `REV_ID_DEFAULT, // arbitrary value
   parameter logic [11:0] PERIPH_LO  = `PERIPH_BASE,
   parameter int          BRK_CYCLES = `BREAK_CLOCKS,
   parameter int          BUF_DEPTH  = 2
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        resetn,
   // received bytes
   input  wire logic        rx_valid,
   input  wire logic [7:0]  rx_data,
   output logic             rx_ready,
   // response bytes
   output logic             tx_valid,
   output logic [7:0]       tx_data,
   input  wire logic        tx_ready,
   // link errors
   input  wire logic        link_break,
   input  wire logic        framing_error,
   input  wire logic        tx_collision,
   // debug link pin drive
   output logic             debug_link_pin_out,
   output logic             debug_link_pin_oe,
   // debug state
   input  wire logic        read_protect_bit,
   input  wire logic [7:0]  debug_status_register,
   output logic [7:0]       debug_control_register,
   output logic             debug_mode,
   // debug counter
   input  wire logic [15:0] debug_counter,
   output logic             counter_load,
   output logic [15:0]      counter_load_data,
   // program counter
   input  wire logic [15:0] pc_value,
   output logic             pc_load,
   output logic [15:0]      pc_load_data,
   // register file
   output logic             rf_wr,
   output logic             rf_rd,
   output logic [11:0]      rf_addr,
   output logic [7:0]       rf_wdata,
   input  wire logic [7:0]  rf_rdata,
   // other command units
   output logic             ext_cmd_valid,
   output logic             ext_cmd_allowed,
   output logic [7:0]       ext_cmd_code
);
   import debug_cmd_pkg::*;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   dcd_s r_r;
   dcd_s r_nxt;
   logic link_err;
   logic take;
   logic dbg;
   logic full_ok;
   logic buf_in_ready;
   logic buf_in_valid;
   logic push;
   logic brk_busy;
   logic [23:0] opnd;

   function automatic logic area_ok(input logic d, input logic p,
                                    input logic [11:0] a);
      area_ok = d & (!p | (a >= PERIPH_LO));
   endfunction : area_ok

   function automatic logic [8:0] size_len(input logic [7:0] s);
      size_len = (s == 8'h00) ? `SIZE_ZERO_LEN : {1'b0, s};
   endfunction : size_len

   assign link_err = link_break | framing_error | tx_collision;
   assign dbg      = r_r.ctl[`CTL_DBGMODE_BIT];
   assign full_ok  = dbg & !read_protect_bit;
   assign rx_ready = (r_r.st == S_CMD) | (r_r.st == S_OPND) |
                     (r_r.st == S_WDATA);
   assign take     = rx_valid & rx_ready & !link_err;
   assign buf_in_valid = (r_r.st == S_RESP);
   assign push     = buf_in_valid & buf_in_ready;
   assign opnd     = {r_r.opbuf[15:0], rx_data};

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign debug_control_register = r_r.ctl;
   assign debug_mode             = dbg;
   assign counter_load           = r_r.cnt_load;
   assign counter_load_data      = r_r.cnt_data;
   assign pc_load                = r_r.pc_load;
   assign pc_load_data           = r_r.pc_data;
   assign rf_wr                  = r_r.rf_wr;
   assign rf_rd                  = r_r.rf_rd;
   assign rf_addr                = r_r.rf_addr;
   assign rf_wdata               = r_r.rf_wdata;
   assign ext_cmd_valid          = r_r.ext_valid;
   assign ext_cmd_allowed        = r_r.ext_allowed;
   assign ext_cmd_code           = r_r.ext_code;
   assign debug_link_pin_out     = 1'b0;
   assign debug_link_pin_oe      = brk_busy;

   // ----------------------------------------------------------------
   // command sequencing
   // ----------------------------------------------------------------
   always_comb begin
      r_nxt = r_r;
      r_nxt.cnt_load  = 1'b0;
      r_nxt.pc_load   = 1'b0;
      r_nxt.rf_wr     = 1'b0;
      r_nxt.rf_rd     = 1'b0;
      r_nxt.ext_valid = 1'b0;
      r_nxt.brk_start = 1'b0;
      unique case (r_r.st)
         S_CMD: begin
            if (take) begin
               r_nxt.cmd   = rx_data;
               r_nxt.opbuf = '0;
               case (rx_data)
                  `CMD_RD_REV: begin
                     r_nxt.rsp   = REV_ID;
                     r_nxt.rsp_n = 2'd2;
                     r_nxt.st    = S_RESP;
                  end
                  `CMD_RD_STAT: begin
                     r_nxt.rsp   = {debug_status_register, 8'h00};
                     r_nxt.rsp_n = 2'd1;
                     r_nxt.st    = S_RESP;
                  end
                  `CMD_RD_CNT: begin
                     r_nxt.rsp   = dbg ? ~debug_counter
                                       : `FILL_WORD;
                     r_nxt.rsp_n = 2'd2;
                     r_nxt.st    = S_RESP;
                  end
                  `CMD_RD_CTL: begin
                     r_nxt.rsp   = {r_r.ctl, 8'h00};
                     r_nxt.rsp_n = 2'd1;
                     r_nxt.st    = S_RESP;
                  end
                  `CMD_RD_PC: begin
                     r_nxt.rsp   = full_ok ? pc_value
                                           : `FILL_WORD;
                     r_nxt.rsp_n = 2'd2;
                     r_nxt.st    = S_RESP;
                  end
                  `CMD_WR_CNT, `CMD_WR_PC: begin
                     r_nxt.opn = 2'd2;
                     r_nxt.st  = S_OPND;
                  end
                  `CMD_WR_CTL: begin
                     r_nxt.opn = 2'd1;
                     r_nxt.st  = S_OPND;
                  end
                  `CMD_WR_REG, `CMD_RD_REG: begin
                     r_nxt.opn = 2'd3;
                     r_nxt.st  = S_OPND;
                  end
                  `CMD_RD_CRC, `CMD_RD_BAUD: begin
                     r_nxt.ext_valid   = 1'b1;
                     r_nxt.ext_allowed = dbg;
                     r_nxt.ext_code    = rx_data;
                  end
                  `CMD_WR_PMEM, `CMD_RD_PMEM, `CMD_WR_DMEM, `CMD_RD_DMEM,
                  `CMD_STEP, `CMD_STUFF, `CMD_EXEC: begin
                     r_nxt.ext_valid   = 1'b1;
                     r_nxt.ext_allowed = full_ok;
                     r_nxt.ext_code    = rx_data;
                  end
                  default: begin
                     r_nxt.st = S_CMD;
                  end
               endcase
            end
         end
         S_OPND: begin
            if (take) begin
               r_nxt.opbuf = opnd;
               r_nxt.opn   = r_r.opn - 2'd1;
               if (r_r.opn == 2'd1) begin
                  r_nxt.st = S_CMD;
                  unique case (r_r.cmd)
                     `CMD_WR_CNT: begin
                        r_nxt.cnt_load = dbg;
                        r_nxt.cnt_data = opnd[15:0];
                     end
                     `CMD_WR_CTL: begin
                        r_nxt.ctl = rx_data;
                     end
                     `CMD_WR_PC: begin
                        r_nxt.pc_load = full_ok;
                        r_nxt.pc_data = opnd[15:0];
                     end
                     default: begin
                        r_nxt.addr = {opnd[19:16], opnd[15:8]};
                        r_nxt.left = size_len(opnd[7:0]);
                        r_nxt.st   = (r_r.cmd == `CMD_WR_REG) ? S_WDATA
                                                              : S_RREQ;
                     end
                  endcase
               end
            end
         end
         S_WDATA: begin
            if (take) begin
               r_nxt.rf_wr    = area_ok(dbg, read_protect_bit,
                                        r_r.addr);
               r_nxt.rf_addr  = r_r.addr;
               r_nxt.rf_wdata = rx_data;
               r_nxt.addr     = r_r.addr + 12'h001;
               r_nxt.left     = r_r.left - 9'h001;
               if (r_r.left == 9'h001) begin
                  r_nxt.st = S_CMD;
               end
            end
         end
         S_RREQ: begin
            r_nxt.rd_ok   = area_ok(dbg, read_protect_bit, r_r.addr);
            r_nxt.rf_rd   = r_nxt.rd_ok;
            r_nxt.rf_addr = r_r.addr;
            r_nxt.st      = S_RDATA;
         end
         S_RDATA: begin
            r_nxt.rsp     = {r_r.rd_ok ? rf_rdata : `FILL_BYTE,
                             8'h00};
            r_nxt.rsp_n   = 2'd1;
            r_nxt.addr    = r_r.addr + 12'h001;
            r_nxt.left    = r_r.left - 9'h001;
            r_nxt.rd_more = (r_r.left != 9'h001);
            r_nxt.st      = S_RESP;
         end
         S_RESP: begin
            if (push) begin
               r_nxt.rsp   = {r_r.rsp[7:0], 8'h00};
               r_nxt.rsp_n = r_r.rsp_n - 2'd1;
               if (r_r.rsp_n == 2'd1) begin
                  r_nxt.st      = r_r.rd_more ? S_RREQ : S_CMD;
                  r_nxt.rd_more = 1'b0;
               end
            end
         end
         S_BREAK: begin
            if (!brk_busy && !r_r.brk_start) begin
               r_nxt.st = S_CMD;
            end
         end
      endcase
      if (link_err) begin
         r_nxt.st        = S_BREAK;
         r_nxt.brk_start = 1'b1;
         r_nxt.rd_more   = 1'b0;
         r_nxt.rsp_n     = 2'd0;
         r_nxt.rf_rd     = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         r_r     <= '0;
         r_r.ctl <= `CTL_RESET;
         r_r.st  <= S_CMD;
      end else begin
         r_r <= r_nxt;
      end
   end

   // ----------------------------------------------------------------
   // response buffer and break drive
   // ----------------------------------------------------------------
   byte_buffer #(
      .WIDTH (8),
      .DEPTH (BUF_DEPTH)
   ) u_rsp_buf (
      .clk       (clk),
      .resetn    (resetn),
      .flush     (r_r.brk_start),
      .in_valid  (buf_in_valid),
      .in_ready  (buf_in_ready),
      .in_data   (r_r.rsp[15:8]),
      .out_valid (tx_valid),
      .out_ready (tx_ready),
      .out_data  (tx_data)
   );

   break_timer #(
      .CYCLES (BRK_CYCLES)
   ) u_brk (
      .clk    (clk),
      .resetn (resetn),
      .start  (r_r.brk_start),
      .busy   (brk_busy)
   );

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence cmd_taken(logic [7:0] c);
      r_r.st == S_CMD && take && rx_data == c;
   endsequence

   sequence break_driven;
      ##[1:3] debug_link_pin_oe;
   endsequence

   rev_order_a: assert property (
      cmd_taken(`CMD_RD_REV) ##1 push |-> r_r.rsp == REV_ID)
      else $error("revision not sent major first");
   cnt_read_a: assert property (
      cmd_taken(`CMD_RD_CNT) |=> r_r.rsp ==
         ($past(dbg) ? ~$past(debug_counter) : `FILL_WORD))
      else $error("counter read value wrong");
   cnt_gate_a: assert property (
      counter_load |-> $past(dbg))
      else $error("counter loaded outside debug mode");
   ctl_write_a: assert property (
      r_r.st == S_OPND && take && r_r.opn == 2'd1 &&
      r_r.cmd == `CMD_WR_CTL |=> debug_control_register == $past(rx_data))
      else $error("control write lost");
   pc_gate_a: assert property (
      pc_load |-> $past(dbg) && !$past(read_protect_bit))
      else $error("pc loaded while gated");
   pc_read_a: assert property (
      cmd_taken(`CMD_RD_PC) ##0 !full_ok |=> r_r.rsp == `FILL_WORD)
      else $error("gated pc read not all ones");
   rf_wr_gate_a: assert property (
      rf_wr |-> $past(dbg) &&
         (!$past(read_protect_bit) || rf_addr >= PERIPH_LO))
      else $error("register write not gated");
   rd_fill_a: assert property (
      r_r.st == S_RDATA && !r_r.rd_ok && !link_err |=>
         r_r.rsp[15:8] == `FILL_BYTE)
      else $error("gated read not filled");
   ext_gate_a: assert property (
      ext_cmd_valid && ext_cmd_allowed |-> $past(dbg))
      else $error("command allowed outside debug mode");
   abort_break_a: assert property (
      link_err |=> r_r.st == S_BREAK ##0 break_driven)
      else $error("error did not start break");
   nop_cmd_a: assert property (
      cmd_taken(8'h0F) ##0 !link_err |=> r_r.st == S_CMD && !push)
      else $error("reserved command not ignored");
endmodule : debug_command_decoder

//--- sim/host_link_model.sv
// Purpose: host adapter model on the byte side of the decoder
// Assumes: bytes queued by the bench go out in queue order
// Notes:   tx_ready stalls at random while slow is high
`timescale 1ns/100ps
module host_link_model (
   // clock and reset
   input  wire logic  clk,
   input  wire logic  resetn,
   input  wire logic  slow,
   // bytes toward the decoder
   output logic       rx_valid,
   output logic [7:0] rx_data,
   input  wire logic  rx_ready,
   // bytes from the decoder
   output logic       tx_ready
);
   logic [7:0] q[$];

   task automatic put(input logic [7:0] b);
      q.push_back(b);
   endtask : put

   // offer held until taken; idle data keeps toggling
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rx_valid <= 1'b0;
         rx_data  <= 8'h00;
         tx_ready <= 1'b0;
      end else begin
         tx_ready <= slow ? ($urandom % 3 == 0) : 1'b1;
         if (!rx_valid || rx_ready) begin
            rx_valid <= q.size() > 0;
            rx_data  <= q.size() > 0 ? q.pop_front() : ~rx_data;
         end
      end
   end
endmodule : host_link_model

//--- sim/debug_command_decoder_bench.sv
// Purpose: self-checking bench of the debug command decoder
// Assumes: host_link_model feeds bytes, bench drives the rest
// Notes:   break length shortened to 16 clocks
`timescale 1ns/100ps
module debug_command_decoder_bench;
   import debug_cmd_pkg::*;
   localparam logic [15:0] REV = 16'h0100; // arbitrary value
   localparam int          BRK = 16;
   logic        clk, resetn, slow, rx_valid, rx_ready, tx_valid, tx_ready;
   logic [7:0]  rx_data, tx_data, stat, ctl, rf_rdata, rf_wdata, code;
   logic        lbrk, ferr, tcol, pin_out, pin_oe, prot, dbg, cl, pl;
   logic        rf_wr, rf_rd, ev_v, ev_ok;
   logic [15:0] cnt, cld, pc, pld;
   logic [11:0] rf_addr;
   logic [7:0]  junk, e8;
   logic [7:0]  txq[$];
   logic [31:0] evq[$];
   int          fails, samples_checked, n;

   debug_command_decoder #(.REV_ID(REV), .BRK_CYCLES(BRK)) dut (
      .clk(clk), .resetn(resetn), .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_ready(tx_ready), .link_break(lbrk), .framing_error(ferr),
      .tx_collision(tcol), .debug_link_pin_out(pin_out),
      .debug_link_pin_oe(pin_oe), .read_protect_bit(prot),
      .debug_status_register(stat), .debug_control_register(ctl),
      .debug_mode(dbg), .debug_counter(cnt), .counter_load(cl),
      .counter_load_data(cld), .pc_value(pc), .pc_load(pl),
      .pc_load_data(pld), .rf_wr(rf_wr), .rf_rd(rf_rd), .rf_addr(rf_addr),
      .rf_wdata(rf_wdata), .rf_rdata(rf_rdata), .ext_cmd_valid(ev_v),
      .ext_cmd_allowed(ev_ok), .ext_cmd_code(code));

   host_link_model host (
      .clk(clk), .resetn(resetn), .slow(slow), .rx_valid(rx_valid),
      .rx_data(rx_data), .rx_ready(rx_ready), .tx_ready(tx_ready));

   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   task automatic chk8(input string nm, input logic [7:0] e, g);
      samples_checked++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk8

   task automatic chk32(input string nm, input logic [31:0] e, g);
      samples_checked++;
      if (g !== e) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk32

   task automatic snd(input logic [7:0] b[$]);
      foreach (b[i]) host.put(b[i]);
   endtask : snd

   task automatic exp(input logic [7:0] b[$]);
      foreach (b[i]) txq.push_back(b[i]);
   endtask : exp

   task automatic ev(input logic [3:0] k, input logic [27:0] v);
      evq.push_back({k, v});
   endtask : ev

   function automatic logic [31:0] evp();
      return evq.size() > 0 ? evq.pop_front() : 'x;
   endfunction : evp

   // wait until all bytes are sent and all answers seen
   task automatic done;
      n = 0;
      while ((host.q.size() > 0 || txq.size() > 0 || !rx_ready) && n < 4000)
      begin
         @(posedge clk);
         n++;
      end
      chk32("done_wait", 32'h0, 32'(n / 4000));
      repeat (4) @(posedge clk);
   endtask : done

   task automatic stop_test;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : stop_test

   // -------------------------------------------------------------
   // clock, register file, watcher, watchdog
   // -------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // register file answers in the same cycle as rf_rd
   always @(posedge clk) junk <= 8'($urandom);
   assign rf_rdata = rf_rd ? ~rf_addr[7:0] : junk;

   always @(posedge clk) begin
      if (resetn) begin
         if (tx_valid && tx_ready) begin
            e8 = txq.size() > 0 ? txq.pop_front() : 'x;
            chk8("tx_data", e8, tx_data);
         end
         if (rf_wr)
            chk32("rf_wr", evp(), {12'h100, rf_addr, rf_wdata});
         if (cl) chk32("counter_load", evp(), {16'h2000, cld});
         if (pl) chk32("pc_load", evp(), {16'h3000, pld});
         if (ev_v) chk32("ext_cmd", evp(), {4'h4, 19'h0, ev_ok, code});
      end
   end

   initial begin
      #3_000_000;
      fails++;
      stop_test;
   end

   // -------------------------------------------------------------
   // tests
   // -------------------------------------------------------------
   initial begin
      {resetn, slow, lbrk, ferr, tcol, prot} = '0;
      {stat, cnt, pc} = '0;
      void'($urandom(32'h57309431));
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      chk8("ctl_reset", 8'h00, ctl);
      stat <= 8'($urandom);
      cnt  <= 16'($urandom);
      pc   <= 16'($urandom);
      @(posedge clk);
      snd({8'h00});
      exp({REV[15:8], REV[7:0]});
      snd({8'h02});
      exp({stat});
      snd({8'h03});
      exp({8'hFF, 8'hFF});
      snd({8'h07});
      exp({8'hFF, 8'hFF});
      snd({8'h01, 8'h12, 8'h34, 8'h06, 8'h12, 8'h34});
      snd({8'h08, 8'h00, 8'h10, 8'h01, 8'h55});
      snd({8'h09, 8'h00, 8'h10, 8'h02});
      exp({8'hFF, 8'hFF});
      snd({8'h10});
      ev(4, {19'h0, 1'b0, 8'h10});
      snd({8'h0F, 8'h05});
      exp({8'h00});
      snd({8'h04, 8'h80});
      done;
      chk8("debug_mode", 8'h01, {7'h0, dbg});
      snd({8'h05});
      exp({8'h80});
      snd({8'h03});
      exp({~cnt[15:8], ~cnt[7:0]});
      snd({8'h07});
      exp({pc[15:8], pc[7:0]});
      snd({8'h01, 8'hA5, 8'h5A, 8'h06, 8'hBE, 8'hEF});
      ev(2, 28'h000A55A);
      ev(3, 28'h000BEEF);
      snd({8'h08, 8'h00, 8'hFF, 8'h02, 8'h11, 8'h22});
      ev(1, 28'h00FF11);
      ev(1, 28'h010022);
      snd({8'h09, 8'h01, 8'hFE, 8'h03});
      exp({8'h01, 8'h00, 8'hFF});
      snd({8'h0E});
      ev(4, {19'h0, 1'b1, 8'h0E});
      done;
      prot <= 1'b1;
      @(posedge clk);
      snd({8'h07});
      exp({8'hFF, 8'hFF});
      snd({8'h06, 8'h12, 8'h34, 8'h08, 8'h00, 8'h20, 8'h01, 8'h77});
      snd({8'h08, 8'h0F, 8'h01, 8'h01, 8'h66});
      ev(1, 28'h0F0166);
      snd({8'h09, 8'h00, 8'h20, 8'h01, 8'h09, 8'h0F, 8'h02, 8'h01});
      exp({8'hFF, 8'hFD});
      snd({8'h10, 8'h01, 8'h00, 8'h07});
      ev(4, {19'h0, 1'b0, 8'h10});
      ev(2, 28'h0000007);
      done;
      prot <= 1'b0;
      slow <= 1'b1;
      @(posedge clk);
      snd({8'h09, 8'h03, 8'h00, 8'h00});
      for (int i = 0; i < 256; i++) exp({~i[7:0]});
      done;
      slow <= 1'b0;
      for (int k = 0; k < 3; k++) begin
         snd({8'h01, 8'h12});
         repeat (6) @(posedge clk);
         {lbrk, ferr, tcol} <= 3'b100 >> k;
         @(posedge clk);
         {lbrk, ferr, tcol} <= 3'b000;
         n = 0;
         repeat (BRK + 20) begin
            @(negedge clk);
            if (pin_oe === 1'b1 && pin_out === 1'b0) n++;
         end
         chk32("break_len", BRK, n);
      end
      snd({8'h05});
      exp({8'h80});
      done;
      chk32("tx_left", 32'h0, 32'(txq.size()));
      chk32("ev_left", 32'h0, 32'(evq.size()));
      stop_test;
   end
endmodule : debug_command_decoder_bench
